/* bench/hpscs_slot_model.sv */
`timescale 1ns/1ns
// Slot side: sensors follow the bench, controller finishes commands late
module hpscs_slot_model #(
  parameter int DONE_DLY = 2  // Cycles from command to completion
) (
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rstn,
  // Command and sensor wishes
  input  wire logic       i_cmd_req,
  input  wire logic [4:0] i_pins,
  // Sensor pins and completion pulse
  output logic      [4:0] o_pins,
  output logic            o_cmd_done
);
  logic [3:0] cnt_reg;  // Cycles left before completion

  // Sensors move just after an edge, as a real slot would not align
  always_ff @(posedge i_clk) begin
    o_pins <= i_pins;
  end

  // Completion is a single pulse, DONE_DLY cycles after the request
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt_reg    <= 4'h0;
      o_cmd_done <= 1'b0;
    end else begin
      o_cmd_done <= (cnt_reg == 4'h1);
      if (i_cmd_req) begin
        cnt_reg <= DONE_DLY[3:0];
      end else if (cnt_reg != 4'h0) begin
        cnt_reg <= cnt_reg - 4'h1;
      end
    end
  end
endmodule : hpscs_slot_model

/* bench/hpscs_top_tb.sv */
`timescale 1ns/1ns
// Self-checking bench for the slot control and status word
module hpscs_top_tb import hpscs_pkg::*;;
  logic        clk     = 1'b0;
  logic        rstn    = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [11:0] paddr   = 12'h000;
  logic [31:0] pwdata  = 32'h0;
  logic [3:0]  pstrb   = 4'h0;
  logic [4:0]  want    = 5'h18;  // Slot fitted, card present
  logic        link    = 1'b0;
  logic [4:0]  pins;
  logic        done;
  logic [31:0] prdata;
  logic        pready, pslverr, creq, amsg, pmsg, poff, irq, wake;
  logic [1:0]  aind, pind;
  logic [31:0] rd;
  logic        er;
  int          n_mismatch  = 0;
  int          checks_done = 0;
  wire logic [7:0] outs = {amsg, pmsg, creq, poff, pind, aind};

  always #50 clk = ~clk;

  hpscs_slot_model #(.DONE_DLY(2)) i_slot (.i_clk(clk), .i_rstn(rstn),
    .i_cmd_req(creq), .i_pins(want), .o_pins(pins), .o_cmd_done(done));

  hpscs_top i_dut (.I_REF_CLK(clk), .I_RSTN(rstn), .I_PSEL(psel),
    .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr),
    .I_PWDATA(pwdata), .I_PSTRB(pstrb), .O_PRDATA(prdata),
    .O_PREADY(pready), .O_PSLVERR(pslverr), .I_ATTN_BTN(pins[0]),
    .I_PWR_FAULT(pins[1]), .I_LATCH_OPEN(pins[2]), .I_CARD_PRES(pins[3]),
    .I_SLOT_IMPL(pins[4]), .I_LINK_ACTIVE(link), .I_CMD_DONE(done),
    .O_ATTN_IND(aind), .O_PWR_IND(pind), .O_SLOT_PWR_OFF(poff),
    .O_CMD_REQ(creq), .O_ATTN_MSG_REQ(amsg), .O_PWR_MSG_REQ(pmsg),
    .O_HP_IRQ(irq), .O_HP_WAKE(wake));

  ////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string nm, input logic [31:0] exp,
                     input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // One APB transfer; values read at the edge are the pre-update ones
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, input logic [3:0] s);
    int n;
    @(posedge clk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    pstrb  <= s;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      n_mismatch++;
      tally_and_finish();
    end
  endtask : apb

  // Write the slot word, then let the edge's updates land
  task automatic wr(input logic [31:0] d, input logic [3:0] s);
    apb(1'b1, SLOT_REG_ADDR, d, s);
    #1;
  endtask : wr

  task automatic rdc(input string nm, input logic [31:0] exp);
    apb(1'b0, SLOT_REG_ADDR, 32'h0, 4'h0);
    chk(nm, exp, rd);
  endtask : rdc

  ////////////////////////////////////////////////////////////////////////
  // Full write: every writable bit, both messages, one command
  task automatic t_ctrl();
    wr(32'h0000ffff, 4'h3);
    chk("outs", 8'hff, outs);
    repeat (8) @(posedge clk);
    rdc("word", 32'h005017fb);
    #1;
    chk("irq", 32'(irq), 1);
    wr(32'h00100000, 4'h4);
    chk("outs", 8'h1f, outs);
    rdc("word", 32'h004017fb);
    chk("irq", 32'(irq), 0);
    $display("done ctrl");
  endtask : t_ctrl

  // Every indicator code, each write sends both messages
  task automatic t_ind();
    for (int v = 1; v < 4; v++) begin
      wr(32'h103b | (v << 6) | (v << 8), 4'h3);
      chk("outs", {4'he, 2'(v), 2'(v)}, outs);
    end
    repeat (8) @(posedge clk);
    wr(32'h00100000, 4'h4);
    rdc("word", 32'h004013fb);
    $display("done ind");
  endtask : t_ind

  // Sensor and link events, masking by bit 5, clearing by one
  task automatic t_evt();
    want <= 5'h17;
    link <= 1'b1;
    repeat (10) @(posedge clk);
    rdc("word", 32'h012f13fb);
    #1;
    chk("irq", 32'({irq, wake}), 3);
    wr(32'h000000db, 4'h1);
    chk("outs", 8'haf, outs);
    repeat (2) @(posedge clk);
    #1;
    chk("irq", 32'({irq, wake}), 1);
    repeat (8) @(posedge clk);
    wr(32'h011f0000, 4'hc);
    rdc("word", 32'h002413db);
    #1;
    chk("wake", 32'(wake), 0);
    $display("done evt");
  endtask : t_evt

  // Unmapped place, then a port with no slot fitted
  task automatic t_edge();
    apb(1'b0, 12'h0fc, 32'h0, 4'h0);
    chk("err", 32'(er), 32'h1);
    chk("rdata", rd, 32'h0);
    apb(1'b1, 12'h0fc, 32'hffffffff, 4'hf);
    chk("werr", 32'(er), 32'h1);
    want <= 5'h07;
    repeat (10) @(posedge clk);
    rdc("word", 32'h006413db);
    chk("err", 32'(er), 0);
    $display("done edge");
  endtask : t_edge

  initial begin
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    rdc("reset", 32'h004003c0);
    chk("outs", 8'h0f, outs);
    chk("irq", 32'({irq, wake}), 0);
    $display("done reset");
    t_ctrl();
    t_ind();
    t_evt();
    t_edge();
    tally_and_finish();
  end
endmodule : hpscs_top_tb

/* logic/hpscs_flag.sv */
`timescale 1ns/1ns
// Sticky event flag; a set in the clearing cycle wins over the clear
module hpscs_flag (
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_rstn,
  // Event and clear
  input  wire logic i_set,
  input  wire logic i_clr,
  // Flag value
  output logic      o_flag
);

  // Set has priority so no event is lost
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_flag <= 1'b0;
    end else if (i_set) begin
      o_flag <= 1'b1;
    end else if (i_clr) begin
      o_flag <= 1'b0;
    end
  end

endmodule : hpscs_flag

/* logic/hpscs_pkg.sv */
// Function
// [R1] Bit 0 enables button-press interrupt or wakeup
// [R2] Bit 1 enables power-fault interrupt or wakeup
// [R3] Bit 3 enables presence-change interrupt or wakeup
// [R4] Bit 4 enables command-completed interrupt
// [R5] Bit 5 gates all hot-plug interrupts
// [R6] Attention indicator bits 7:6, reset off
// [R7] Attention field write sends attention message
// [R8] Power indicator bits 9:8, reset off
// [R9] Power field write sends power message
// [R10] Bit 10 requests slot power off
// [R11] Bit 12 enables link-active change notification
// [R12] Status 16 button pressed, write one clears
// [R13] Status 17 power fault, write one clears
// [R14] Status 18 latch changed, read only
// [R15] Status 19 presence changed, write one clears
// [R16] Status 20 command completed, write one clears
// [R17] Status 21 shows retention latch open
// [R18] Status 22 shows card present, resets one
// [R19] No slot implemented: presence reads one
// [R20] Status 24 link-active changed, write one clears
// [R21] Downstream only; reserved bits read zero
// [R22] Interrupt while enabled event flag set
// [R23] Issued command later sets command completed
package hpscs_pkg;

  // Register map: control in the low half, status in the high half
  localparam logic [11:0] SLOT_REG_ADDR   = 12'h0f8;

  // Control field positions
  localparam int          BTN_EN_BIT      = 0;
  localparam int          FAULT_EN_BIT    = 1;
  localparam int          PRES_EN_BIT     = 3;
  localparam int          CMD_EN_BIT      = 4;
  localparam int          HP_IRQ_EN_BIT   = 5;
  localparam int          ATTN_LO_BIT     = 6;
  localparam int          PWR_IND_LO_BIT  = 8;
  localparam int          PWR_OFF_BIT     = 10;
  localparam int          LINK_EN_BIT     = 12;

  // Status field positions inside the 32-bit word
  localparam int          BTN_ST_BIT      = 16;
  localparam int          FAULT_ST_BIT    = 17;
  localparam int          PRES_ST_BIT     = 19;
  localparam int          CMD_ST_BIT      = 20;
  localparam int          LINK_ST_BIT     = 24;

  // Writable control bits; reserved 2, 11, 15:13 stay zero
  localparam logic [15:0] CTRL_WR_MASK    = 16'h17fb;
  // Control reset: both indicators off, everything else clear
  localparam logic [15:0] CTRL_RST        = 16'h03c0;
  // Card presence reads one until the pins have been sampled
  localparam logic        PRES_RST        = 1'b1;
  // Link-active reporting is implemented on this port
  localparam logic        LINK_RPT_IMPL   = 1'b1;

  // Indicator encodings
  localparam logic [1:0]  IND_ON          = 2'h1;
  localparam logic [1:0]  IND_BLINK       = 2'h2;
  localparam logic [1:0]  IND_OFF         = 2'h3;

  // Synchronised pin vector layout and reset value
  localparam int          PIN_W           = 5;
  localparam int          PIN_BTN         = 0;
  localparam int          PIN_FAULT       = 1;
  localparam int          PIN_LATCH       = 2;
  localparam int          PIN_PRES        = 3;
  localparam int          PIN_SLOT        = 4;
  localparam logic [4:0]  PIN_RST         = 5'h08;

  // Slot controller command tracking
  typedef enum logic {
    CMD_IDLE = 1'b0,
    CMD_BUSY = 1'b1
  } hpscs_cmd_t;

endpackage : hpscs_pkg

/* logic/hpscs_sync.sv */
`timescale 1ns/1ns
// Two-flop synchroniser for slot pins; first stage feeds only the second
module hpscs_sync #(
  parameter int                 W   = 1,
  parameter logic [W-1:0]       RST = '0
) (
  // Clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_rstn,
  // Asynchronous levels in, clock-domain levels out
  input  wire logic [W-1:0]     i_d,
  output logic      [W-1:0]     o_q
);

  logic [W-1:0] meta_reg;  // First stage, may go metastable

  // Both stages reset to the same constant
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      meta_reg <= RST;
      o_q      <= RST;
    end else begin
      meta_reg <= i_d;
      o_q      <= meta_reg;
    end
  end

endmodule : hpscs_sync

/* logic/hpscs_top.sv */
// Added by the designer: the APB register port.
`timescale 1ns/1ns
// Hot-plug slot control and status word for a downstream port
module hpscs_top
  import hpscs_pkg::*;
(
  // Clock and reset
  input  wire logic        I_REF_CLK,
  input  wire logic        I_RSTN,
  // APB slave
  input  wire logic        I_PSEL,
  input  wire logic        I_PENABLE,
  input  wire logic        I_PWRITE,
  input  wire logic [11:0] I_PADDR,
  input  wire logic [31:0] I_PWDATA,
  input  wire logic [3:0]  I_PSTRB,
  output logic      [31:0] O_PRDATA,
  output logic             O_PREADY,
  output logic             O_PSLVERR,
  // Slot pins, asynchronous
  input  wire logic        I_ATTN_BTN,
  input  wire logic        I_PWR_FAULT,
  input  wire logic        I_LATCH_OPEN,
  input  wire logic        I_CARD_PRES,
  input  wire logic        I_SLOT_IMPL,
  // Link layer and slot controller, same clock
  input  wire logic        I_LINK_ACTIVE,
  input  wire logic        I_CMD_DONE,
  // Slot control outputs
  output logic      [1:0]  O_ATTN_IND,
  output logic      [1:0]  O_PWR_IND,
  output logic             O_SLOT_PWR_OFF,
  output logic             O_CMD_REQ,
  // Indicator message send requests
  output logic             O_ATTN_MSG_REQ,
  output logic             O_PWR_MSG_REQ,
  // Hot-plug interrupt and wakeup
  output logic             O_HP_IRQ,
  output logic             O_HP_WAKE
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  ////////////////////////////////////////////////////////////////////////////

  logic [15:0]      ctrl_reg;      // Slot control half
  logic [PIN_W-1:0] pin_q;         // Synchronised slot pins
  logic [PIN_W-1:0] pin_prev_reg;  // Pins one cycle earlier
  logic             link_prev_reg; // Link active one cycle earlier
  hpscs_cmd_t       cmd_reg;       // Slot controller command state
  hpscs_cmd_t       cmd_next;      // Its next value
  logic             pready_reg;    // Access-phase ready
  logic             pslverr_reg;   // Unmapped address answer
  logic [31:0]      prdata_reg;    // Captured read word
  logic             irq_reg;       // Interrupt output flop
  logic             wake_reg;      // Wakeup output flop
  logic             attn_msg_reg;  // Attention message pulse
  logic             pwr_msg_reg;   // Power message pulse
  logic             cmd_req_reg;   // Command start pulse

  logic             addr_hit;      // Address selects the slot word
  logic             setup_ph;      // APB setup cycle
  logic             wr_hit;        // Write taken this edge
  logic             btn_press;     // Button rising edge
  logic             fault_det;     // Power fault rising edge
  logic             latch_chg;     // Latch sensor changed
  logic             pres_chg;      // Presence detect changed
  logic             link_chg;      // Link active changed
  logic             cmd_issue;     // Software issued a command
  logic             cmd_done_evt;  // Slot controller finished
  logic             pres_state;    // Presence as software sees it
  logic             btn_flag;      // Status flags
  logic             fault_flag;
  logic             latch_flag;
  logic             pres_flag;
  logic             cmd_flag;
  logic             link_flag;
  logic             wake_evt;      // Enabled events that may wake
  logic             irq_evt;       // Enabled events that may interrupt
  logic [31:0]      rd_word;       // Live read value

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation and event detection
  ////////////////////////////////////////////////////////////////////////////

  // All slot pins cross into the clock domain through two flops
  hpscs_sync #(
    .W   (PIN_W),
    .RST (PIN_RST)
  ) u_pin_sync (
    .i_clk  (I_REF_CLK),
    .i_rstn (I_RSTN),
    .i_d    ({I_SLOT_IMPL, I_CARD_PRES, I_LATCH_OPEN,
              I_PWR_FAULT, I_ATTN_BTN}),
    .o_q    (pin_q)
  );

  // Previous pin and link values for edge detection
  always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      pin_prev_reg  <= PIN_RST;
      link_prev_reg <= 1'b0;
    end else begin
      pin_prev_reg  <= pin_q;
      link_prev_reg <= I_LINK_ACTIVE;
    end
  end

  // A press or a fault counts once, on its leading edge
  assign btn_press = pin_q[PIN_BTN] & ~pin_prev_reg[PIN_BTN];
  assign fault_det = pin_q[PIN_FAULT] & ~pin_prev_reg[PIN_FAULT];
  // Latch and presence report any change in either direction
  assign latch_chg = pin_q[PIN_LATCH] ^ pin_prev_reg[PIN_LATCH];
  // Presence changes only matter where a slot exists
  assign pres_chg  = pin_q[PIN_SLOT] &
                     (pin_q[PIN_PRES] ^ pin_prev_reg[PIN_PRES]);
  // Link change only when reporting is implemented
  assign link_chg  = LINK_RPT_IMPL &
                     (I_LINK_ACTIVE ^ link_prev_reg); // R20

  // Without a slot the presence bit is forced to one
  assign pres_state = ~pin_q[PIN_SLOT] | pin_q[PIN_PRES]; // R18 R19

  ////////////////////////////////////////////////////////////////////////////
  // APB slave
  ////////////////////////////////////////////////////////////////////////////

  // Only the one slot word is mapped; this block sits on a downstream port
  assign addr_hit = (I_PADDR == SLOT_REG_ADDR); // R21
  assign setup_ph = I_PSEL & ~I_PENABLE;
  // Writes take effect at the edge that completes the access phase
  assign wr_hit   = I_PSEL & I_PENABLE & pready_reg & I_PWRITE & addr_hit;

  // Read word; reserved bits 2, 11, 15:13, 23, 31:25 are zero
  assign rd_word = {7'h00,                          // R21
                    link_flag,                      // R20
                    1'b0,                           // R21
                    pres_state,                     // R18
                    pin_q[PIN_LATCH],               // R17
                    cmd_flag,
                    pres_flag,
                    latch_flag,                     // R14
                    fault_flag,
                    btn_flag,
                    ctrl_reg};

  // Fixed one-cycle access: ready rises in every access phase
  always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg  <= setup_ph;
      pslverr_reg <= setup_ph & ~addr_hit;
    end
  end

  // Read data sampled in setup; zero for writes and unmapped reads
  always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      prdata_reg <= 32'h0000_0000;
    end else if (setup_ph & ~I_PWRITE & addr_hit) begin
      prdata_reg <= rd_word;
    end else begin
      prdata_reg <= 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Slot control register
  ////////////////////////////////////////////////////////////////////////////

  // Byte lanes 0 and 1 hold control; reserved bits are masked off
  always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      ctrl_reg <= CTRL_RST; // R6 R8 R10
    end else if (wr_hit) begin
      if (I_PSTRB[0]) begin
        ctrl_reg[7:0] <= I_PWDATA[7:0] & CTRL_WR_MASK[7:0]; // R6
      end
      if (I_PSTRB[1]) begin
        ctrl_reg[15:8] <= I_PWDATA[15:8] & CTRL_WR_MASK[15:8]; // R8
      end
    end
  end

  // Every write to a lane carrying an indicator sends its message
  always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      attn_msg_reg <= 1'b0;
      pwr_msg_reg  <= 1'b0;
    end else begin
      attn_msg_reg <= wr_hit & I_PSTRB[0]; // R7
      pwr_msg_reg  <= wr_hit & I_PSTRB[1]; // R9
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Slot controller command tracking
  ////////////////////////////////////////////////////////////////////////////

  // Indicator or power writes are commands to the slot controller
  assign cmd_issue    = wr_hit & (I_PSTRB[0] | I_PSTRB[1]);
  // A done strobe outside a command is ignored
  assign cmd_done_evt = (cmd_reg == CMD_BUSY) & I_CMD_DONE; // R23

  // A new command while busy restarts it; one completion covers both
  always_comb begin
    cmd_next = cmd_reg;
    unique case (cmd_reg)
      CMD_IDLE: begin
        if (cmd_issue) begin
          cmd_next = CMD_BUSY;
        end
      end
      CMD_BUSY: begin
        if (cmd_issue) begin
          cmd_next = CMD_BUSY;
        end else if (I_CMD_DONE) begin
          cmd_next = CMD_IDLE; // R23
        end
      end
    endcase
  end

  // Command state and start pulse
  always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      cmd_reg     <= CMD_IDLE;
      cmd_req_reg <= 1'b0;
    end else begin
      cmd_reg     <= cmd_next;
      cmd_req_reg <= cmd_issue;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Slot status flags
  ////////////////////////////////////////////////////////////////////////////

  // Button pressed, cleared by writing one to bit 16
  hpscs_flag u_btn_flag (
    .i_clk  (I_REF_CLK),
    .i_rstn (I_RSTN),
    .i_set  (btn_press),
    .i_clr  (wr_hit & I_PSTRB[2] & I_PWDATA[BTN_ST_BIT]), // R12
    .o_flag (btn_flag)
  );

  // Power fault, cleared by writing one to bit 17
  hpscs_flag u_fault_flag (
    .i_clk  (I_REF_CLK),
    .i_rstn (I_RSTN),
    .i_set  (fault_det),
    .i_clr  (wr_hit & I_PSTRB[2] & I_PWDATA[FAULT_ST_BIT]), // R13
    .o_flag (fault_flag)
  );

  // Latch changed is read-only, so only reset clears it
  hpscs_flag u_latch_flag (
    .i_clk  (I_REF_CLK),
    .i_rstn (I_RSTN),
    .i_set  (latch_chg), // R14
    .i_clr  (1'b0),
    .o_flag (latch_flag)
  );

  // Presence changed, cleared by writing one to bit 19
  hpscs_flag u_pres_flag (
    .i_clk  (I_REF_CLK),
    .i_rstn (I_RSTN),
    .i_set  (pres_chg),
    .i_clr  (wr_hit & I_PSTRB[2] & I_PWDATA[PRES_ST_BIT]), // R15
    .o_flag (pres_flag)
  );

  // Command completed, cleared by writing one to bit 20
  hpscs_flag u_cmd_flag (
    .i_clk  (I_REF_CLK),
    .i_rstn (I_RSTN),
    .i_set  (cmd_done_evt),
    .i_clr  (wr_hit & I_PSTRB[2] & I_PWDATA[CMD_ST_BIT]), // R16
    .o_flag (cmd_flag)
  );

  // Link active changed, cleared by writing one to bit 24
  hpscs_flag u_link_flag (
    .i_clk  (I_REF_CLK),
    .i_rstn (I_RSTN),
    .i_set  (link_chg),
    .i_clr  (wr_hit & I_PSTRB[3] & I_PWDATA[LINK_ST_BIT]), // R20
    .o_flag (link_flag)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt and wakeup
  ////////////////////////////////////////////////////////////////////////////

  // Wakeup is not gated by the master enable, so a sleeping port can wake
  assign wake_evt = (btn_flag   & ctrl_reg[BTN_EN_BIT])   | // R1
                    (fault_flag & ctrl_reg[FAULT_EN_BIT]) | // R2
                    (pres_flag  & ctrl_reg[PRES_EN_BIT])  | // R3
                    (link_flag  & ctrl_reg[LINK_EN_BIT]);   // R11
  // Command completion interrupts but never wakes
  assign irq_evt  = wake_evt |
                    (cmd_flag & ctrl_reg[CMD_EN_BIT]); // R4

  // Level interrupt held while bit 5 is set and any enabled flag stays set
  always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      irq_reg  <= 1'b0;
      wake_reg <= 1'b0;
    end else begin
      irq_reg  <= irq_evt & ctrl_reg[HP_IRQ_EN_BIT]; // R5 R22
      wake_reg <= wake_evt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  ////////////////////////////////////////////////////////////////////////////

  assign O_PRDATA       = prdata_reg;
  assign O_PREADY       = pready_reg;
  assign O_PSLVERR      = pslverr_reg;
  assign O_ATTN_IND     = ctrl_reg[ATTN_LO_BIT +: 2];
  assign O_PWR_IND      = ctrl_reg[PWR_IND_LO_BIT +: 2];
  assign O_SLOT_PWR_OFF = ctrl_reg[PWR_OFF_BIT]; // R10
  assign O_CMD_REQ      = cmd_req_reg;
  assign O_ATTN_MSG_REQ = attn_msg_reg;
  assign O_PWR_MSG_REQ  = pwr_msg_reg;
  assign O_HP_IRQ       = irq_reg;
  assign O_HP_WAKE      = wake_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  ////////////////////////////////////////////////////////////////////////////

  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (!I_RSTN);

  irq_master_gate_a: assert property ( // R5
    !ctrl_reg[HP_IRQ_EN_BIT] |=> !O_HP_IRQ)
    else $error("interrupt raised with master enable clear");

  irq_has_cause_a: assert property ( // R22
    O_HP_IRQ |-> $past(irq_evt) && $past(ctrl_reg[HP_IRQ_EN_BIT]))
    else $error("interrupt without an enabled event");

  btn_sets_flag_a: assert property ( // R12
    btn_press |=> btn_flag)
    else $error("button press not recorded");

  btn_w1c_a: assert property ( // R12
    wr_hit && I_PSTRB[2] && I_PWDATA[BTN_ST_BIT] && !btn_press
    |=> !btn_flag)
    else $error("button flag not cleared by write one");

  fault_sets_flag_a: assert property ( // R13
    fault_det |=> fault_flag)
    else $error("power fault not recorded");

  latch_sticky_a: assert property ( // R14
    latch_flag |=> latch_flag)
    else $error("read-only latch flag cleared");

  attn_msg_a: assert property ( // R7
    wr_hit && I_PSTRB[0]
    |=> O_ATTN_MSG_REQ && O_ATTN_IND == $past(I_PWDATA[7:6]))
    else $error("attention write without message");

  pwr_msg_a: assert property ( // R9
    wr_hit && I_PSTRB[1]
    |=> O_PWR_MSG_REQ && O_PWR_IND == $past(I_PWDATA[9:8]))
    else $error("power indicator write without message");

  cmd_complete_a: assert property ( // R23
    cmd_reg == CMD_BUSY && I_CMD_DONE && !cmd_issue
    |=> cmd_flag && cmd_reg == CMD_IDLE)
    else $error("command completion not recorded");

  rsvd_zero_a: assert property ( // R21
    O_PREADY |-> O_PRDATA[31:25] == 7'h00 && !O_PRDATA[23]
    && !O_PRDATA[2] && !O_PRDATA[11] && O_PRDATA[15:13] == 3'h0)
    else $error("reserved bit read as one");

  btn_irq_c:   cover property (btn_press ##[1:3] O_HP_IRQ);
  cmd_done_c:  cover property (cmd_issue ##[1:20] cmd_flag);
  link_chg_c:  cover property (link_chg ##1 link_flag);

endmodule : hpscs_top
